// file: lane_monitor_defines.svh
`ifndef LANE_MONITOR_DEFINES_SVH
`define LANE_MONITOR_DEFINES_SVH

// ****************************************************************
// Observation bus placement
// ****************************************************************
`define OBS_BASE_BIT      448
`define OBS_SLICE_WIDTH   64
`define OBS_LANE_STRIDE   8
`define OBS_LANE_COUNT    4
`define OBS_FILL_LSB      0
`define OBS_FILL_WIDTH    4
`define OBS_CODE_LSB      4
`define OBS_CODE_WIDTH    3
`define OBS_INVERT_BIT    7
`define OBS_RESERVED_LSB  480
`define OBS_RESERVED_MSB  511

// ****************************************************************
// Register map (word index on the plain register port)
// ****************************************************************
`define REG_ADDR_WIDTH    4
`define REG_DATA_WIDTH    32
`define REG_STATUS        4'h0
`define REG_CLEAR         4'h1
`define REG_ENABLE        4'h2
`define REG_FILL          4'h3

// ****************************************************************
// Reset values
// ****************************************************************
`define ENABLE_RESET      4'h0
`define STATUS_RESET      4'h0
`define READ_RESET        32'h0000_0000

`endif

// file: lane_monitor_pkg.sv
package lane_monitor_pkg;

  // ****************************************************************
  // Receive event codes of one lane
  // ****************************************************************
  typedef enum logic [2:0] {
    EV_DATA_GOOD      = 3'h0,
    EV_SKIP_ADDED     = 3'h1,
    EV_SKIP_REMOVED   = 3'h2,
    EV_RX_DETECTED    = 3'h3,
    EV_DECODE_ERROR   = 3'h4,
    EV_ELASTIC_OVER   = 3'h5,
    EV_ELASTIC_UNDER  = 3'h6,
    EV_DISPARITY_ERR  = 3'h7
  } rx_event_type;

  // ****************************************************************
  // One lane's byte on the observation bus, msb first
  // ****************************************************************
  typedef struct packed {
    logic         invert_request;  // Polarity inversion request
    rx_event_type rx_event_code;   // Receive status code
    logic [3:0]   elastic_fill;    // Elastic buffer symbol count
  } lane_obs_type;

endpackage

// file: lane_obs_slice.sv
`timescale 1ns/100ps
`include "lane_monitor_defines.svh"

module lane_obs_slice
  import lane_monitor_pkg::*;
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire lane_obs_type lane_in,
  input  wire logic         generic_phy_mode,
  output      lane_obs_type lane_out,
  output      logic         error_pulse
);

  lane_obs_type lane_reg;    // Captured lane byte
  lane_obs_type lane_next;   // Next lane byte
  logic         error_reg;   // Error event pulse
  logic         error_next;  // Next error pulse

  // Capture lane signals, blanked in generic PHY mode
  always_comb begin
    lane_next  = lane_in;
    error_next = 1'b0;
    if (generic_phy_mode) begin
      lane_next = '0;                                    // [RQ5]
    end else begin
      // Codes from decode error upward are errors
      error_next = lane_in.rx_event_code >= EV_DECODE_ERROR; // [RQ1]
    end
  end

  // Register the slice
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      lane_reg  <= '0;
      error_reg <= 1'b0;
    end else begin
      lane_reg  <= lane_next;
      error_reg <= error_next;
    end
  end

  assign lane_out    = lane_reg;
  assign error_pulse = error_reg;

endmodule

// file: pcs_lane_test_monitor.sv
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
`include "lane_monitor_defines.svh"

// How it works
// (RQ1) Event code: good, skips, detect, four errors
// (RQ2) Lane 1-3 status at 462, 470, 478
// (RQ3) Invert request bits 463, 471, 479
// (RQ4) Fill counts lanes 2, 3 at 467, 475
// (RQ5) Generic PHY mode: lane fields meaningless
// (RQ6) Observers compare fill counts for offset, skew
// (RQ7) Lane 0: fill 451:448, status, bit 455
// (RQ8) Lane 1 fill count at bits 459:456
// (RQ9) Reserved top bits driven constant zero

module pcs_lane_test_monitor
  import lane_monitor_pkg::*;
#(
  parameter int LANES = `OBS_LANE_COUNT
)
(
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // Core configuration
  input  wire logic         generic_phy_mode,
  // Lane 0 sources
  input  wire logic [3:0]   lane0_elastic_fill,
  input  wire logic [2:0]   lane0_rx_event_code,
  input  wire logic         lane0_invert_request,
  // Lane 1 sources
  input  wire logic [3:0]   lane1_elastic_fill,
  input  wire logic [2:0]   lane1_rx_event_code,
  input  wire logic         lane1_invert_request,
  // Lane 2 sources
  input  wire logic [3:0]   lane2_elastic_fill,
  input  wire logic [2:0]   lane2_rx_event_code,
  input  wire logic         lane2_invert_request,
  // Lane 3 sources
  input  wire logic [3:0]   lane3_elastic_fill,
  input  wire logic [2:0]   lane3_rx_event_code,
  input  wire logic         lane3_invert_request,
  // Observation bus bits 511:448
  output      logic [63:0]  obs_slice,
  // Register port
  input  wire logic [3:0]   reg_addr,
  input  wire logic [31:0]  reg_wdata,
  input  wire logic         reg_write,
  input  wire logic         reg_read,
  output      logic [31:0]  reg_rdata,
  // Interrupt
  output      logic         irq
);

  // ****************************************************************
  // Lane sources gathered into carriers
  // ****************************************************************

  lane_obs_type lane_src [LANES];  // Lane inputs as structs
  lane_obs_type lane_obs [LANES];  // Registered lane bytes
  logic [LANES-1:0] lane_error;    // Per-lane error pulses

  // Lane inputs come from core logic on this clock, so no
  // synchroniser stands in front of the carriers
  // Lane 0 carrier
  assign lane_src[0] = '{invert_request: lane0_invert_request,
                         rx_event_code:  rx_event_type'(lane0_rx_event_code),
                         elastic_fill:   lane0_elastic_fill};
  // Lane 1 carrier
  assign lane_src[1] = '{invert_request: lane1_invert_request,
                         rx_event_code:  rx_event_type'(lane1_rx_event_code),
                         elastic_fill:   lane1_elastic_fill};
  // Lane 2 carrier
  assign lane_src[2] = '{invert_request: lane2_invert_request,
                         rx_event_code:  rx_event_type'(lane2_rx_event_code),
                         elastic_fill:   lane2_elastic_fill};
  // Lane 3 carrier
  assign lane_src[3] = '{invert_request: lane3_invert_request,
                         rx_event_code:  rx_event_type'(lane3_rx_event_code),
                         elastic_fill:   lane3_elastic_fill};

  // ****************************************************************
  // Per-lane capture and bus placement
  // ****************************************************************

  // Each lane occupies one byte starting at bit 448
  // Byte layout: fill 3:0, code 6:4, invert 7
  // One slice per lane: capture, blanking, error pulse
  // All fields of a lane leave one register, so a sampled
  // byte never mixes two cycles; generic mode zeroes it
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : gen_lane
      // Capture and error detection for one lane
      lane_obs_slice u_slice (
        .ref_clk          (ref_clk),
        .reset            (reset),
        .lane_in          (lane_src[g]),
        .generic_phy_mode (generic_phy_mode),
        .lane_out         (lane_obs[g]),
        .error_pulse      (lane_error[g])
      );
      // Fill count field
      assign obs_slice[g*`OBS_LANE_STRIDE + `OBS_FILL_LSB +:
                       `OBS_FILL_WIDTH] =
        lane_obs[g].elastic_fill;      // [RQ4] [RQ7] [RQ8]
      // Receive status field
      assign obs_slice[g*`OBS_LANE_STRIDE + `OBS_CODE_LSB +:
                       `OBS_CODE_WIDTH] =
        lane_obs[g].rx_event_code;     // [RQ1] [RQ2] [RQ7]
      // Polarity inversion request bit
      assign obs_slice[g*`OBS_LANE_STRIDE + `OBS_INVERT_BIT] =
        lane_obs[g].invert_request;    // [RQ3] [RQ7]
    end
  endgenerate

  // Reserved bits 511:480 held at zero
  // A fifth lane would overlap these bits, so LANES
  // stays at four
  assign obs_slice[`OBS_RESERVED_MSB-`OBS_BASE_BIT:
                   `OBS_RESERVED_LSB-`OBS_BASE_BIT] = '0; // [RQ9]

  // ****************************************************************
  // Interrupt status, clear and enable
  // ****************************************************************

  logic [LANES-1:0] status_reg;   // Sticky lane error bits
  logic [LANES-1:0] status_next;  // Next sticky bits
  logic [LANES-1:0] enable_reg;   // Interrupt enable bits
  logic [LANES-1:0] enable_next;  // Next enable bits
  logic [LANES-1:0] clear_mask;   // Bits cleared this cycle
  logic             hit_clear;    // Write to clear register
  logic             hit_enable;   // Write to enable register

  // Write decode
  // Status, fill and unmapped words ignore writes
  always_comb begin
    hit_clear  = reg_write && (reg_addr == `REG_CLEAR);
    hit_enable = reg_write && (reg_addr == `REG_ENABLE);
    clear_mask = hit_clear ? reg_wdata[LANES-1:0] : '0;
  end

  // Sticky status and enable next values
  always_comb begin
    // New events win over a clear in the same cycle,
    // so an error arriving during a clear is never lost
    status_next = (status_reg & ~clear_mask) | lane_error; // [RQ1]
    enable_next = enable_reg;
    if (hit_enable) begin
      enable_next = reg_wdata[LANES-1:0];
    end
  end

  // Status and enable registers
  // Reset clears both, so irq starts low
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      status_reg <= LANES'(`STATUS_RESET);
      enable_reg <= LANES'(`ENABLE_RESET);
    end else begin
      status_reg <= status_next;
      enable_reg <= enable_next;
    end
  end

  // Level interrupt while an enabled bit is set
  // Built from registers only, so it cannot glitch
  // on lane inputs; a clear write drops it
  assign irq = |(status_reg & enable_reg);

  // ****************************************************************
  // Register read port
  // ****************************************************************

  localparam int FILL_BITS = LANES * `OBS_FILL_WIDTH;  // Fill view width

  logic [31:0]          rdata_reg;   // Read data, one cycle after strobe
  logic [31:0]          rdata_next;  // Next read data
  logic [FILL_BITS-1:0] fill_view;   // All lane fill counts

  // Gather fill counts, lane 0 in the low nibble
  always_comb begin
    fill_view = '0;
    for (int i = 0; i < LANES; i++) begin
      fill_view[i*`OBS_FILL_WIDTH +: `OBS_FILL_WIDTH] =
        lane_obs[i].elastic_fill;
    end
  end

  // Read mux; unmapped and write-only words read zero
  // Zero outside the read slot lets several ports share
  // one return path through an OR
  always_comb begin
    rdata_next = `READ_RESET;
    if (reg_read) begin
      unique case (reg_addr)
        `REG_STATUS: begin
          rdata_next[LANES-1:0] = status_reg;
        end
        `REG_ENABLE: begin
          rdata_next[LANES-1:0] = enable_reg;
        end
        `REG_FILL: begin
          rdata_next[FILL_BITS-1:0] = fill_view;
        end
        default: begin
          rdata_next = `READ_RESET;
        end
      endcase
    end
  end

  // Read data register; stands one cycle only
  // Reset empties the slot as well
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= `READ_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

endmodule

// file: lane_monitor_checker_asserts.sv
`timescale 1ns/100ps
module lane_monitor_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        generic_phy_mode,
  input wire logic [3:0]  lane0_elastic_fill,
  input wire logic [2:0]  lane0_rx_event_code,
  input wire logic        lane0_invert_request,
  input wire logic [3:0]  lane1_elastic_fill,
  input wire logic [2:0]  lane1_rx_event_code,
  input wire logic        lane1_invert_request,
  input wire logic [3:0]  lane2_elastic_fill,
  input wire logic [2:0]  lane2_rx_event_code,
  input wire logic        lane2_invert_request,
  input wire logic [3:0]  lane3_elastic_fill,
  input wire logic [2:0]  lane3_rx_event_code,
  input wire logic        lane3_invert_request,
  input wire logic [63:0] obs_slice,
  input wire logic [3:0]  reg_addr,
  input wire logic        reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic        irq
);
  // ****************************************************************
  // Observation bus and status checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Lane byte shows the inputs of one edge earlier
  property lane_p(logic [7:0] o, logic [7:0] s);
    !$past(reset) && !$past(generic_phy_mode) |-> o == $past(s);
  endproperty
  lane0_map_a: assert property (
    lane_p(obs_slice[7:0], {lane0_invert_request,
    lane0_rx_event_code, lane0_elastic_fill})) else $error("lane 0 byte");
  lane1_map_a: assert property (
    lane_p(obs_slice[15:8], {lane1_invert_request,
    lane1_rx_event_code, lane1_elastic_fill})) else $error("lane 1 byte");
  lane2_map_a: assert property (
    lane_p(obs_slice[23:16], {lane2_invert_request,
    lane2_rx_event_code, lane2_elastic_fill})) else $error("lane 2 byte");
  lane3_map_a: assert property (
    lane_p(obs_slice[31:24], {lane3_invert_request,
    lane3_rx_event_code, lane3_elastic_fill})) else $error("lane 3 byte");
  phy_zero_a: assert property (
    !$past(reset) && $past(generic_phy_mode) |-> obs_slice[31:0] == 32'h0)
    else $error("generic mode fields");
  reserved_zero_a: assert property (obs_slice[63:32] == 32'h0)
    else $error("reserved bits");
  status_sticky_a: assert property (
    $past(lane2_rx_event_code[2], 3) && !$past(generic_phy_mode, 3) &&
    !$past(reset) && !$past(reset, 2) && !$past(reset, 3) &&
    $past(reg_read) && $past(reg_addr) == 4'h0 |-> reg_rdata[2])
    else $error("lane 2 error not sticky");
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
    else $error("read data outside slot");
  rd_unmapped_a: assert property ($past(reg_read) && ($past(reg_addr) == 4'h1
    || $past(reg_addr) > 4'h3) |-> reg_rdata == 32'h0) else $error("unmapped");
  cover property ($past(reg_read) && reg_rdata != 32'h0);
  cover property (generic_phy_mode && lane3_rx_event_code[2]);
  cover property ($rose(irq));
endmodule
bind pcs_lane_test_monitor lane_monitor_checker u_lane_monitor_checker (
  .ref_clk              (ref_clk),
  .reset                (reset),
  .generic_phy_mode     (generic_phy_mode),
  .lane0_elastic_fill   (lane0_elastic_fill),
  .lane0_rx_event_code  (lane0_rx_event_code),
  .lane0_invert_request (lane0_invert_request),
  .lane1_elastic_fill   (lane1_elastic_fill),
  .lane1_rx_event_code  (lane1_rx_event_code),
  .lane1_invert_request (lane1_invert_request),
  .lane2_elastic_fill   (lane2_elastic_fill),
  .lane2_rx_event_code  (lane2_rx_event_code),
  .lane2_invert_request (lane2_invert_request),
  .lane3_elastic_fill   (lane3_elastic_fill),
  .lane3_rx_event_code  (lane3_rx_event_code),
  .lane3_invert_request (lane3_invert_request),
  .obs_slice            (obs_slice),
  .reg_addr             (reg_addr),
  .reg_read             (reg_read),
  .reg_rdata            (reg_rdata),
  .irq                  (irq)
);

// file: debug_observer.sv
`timescale 1ns/100ps
// Samples the bus; lane 0 to lane 1 fill gap as skew estimate
module debug_observer (
  input  wire logic        ref_clk,
  input  wire logic        generic_phy_mode,
  input  wire logic [63:0] obs_slice,
  output logic signed [4:0] lane_skew,
  output logic             top_dirty
);
  always_ff @(posedge ref_clk) begin
    if (!generic_phy_mode) begin
      lane_skew <= $signed({1'b0, obs_slice[3:0]}) -
                   $signed({1'b0, obs_slice[11:8]});
    end
    top_dirty <= |obs_slice[63:32];
  end
endmodule

// file: tb.sv
`timescale 1ns/100ps
module tb;
  logic        ref_clk = 0, reset = 1, gp = 0;
  logic [31:0] lanes = 32'h0, wdata = 32'h0, rdata, l;
  logic [3:0]  addr = 4'h0;
  logic        wr_s = 0, rd_s = 0, irq, dirty;
  logic [63:0] obs;
  logic signed [4:0] skew;
  int          n_errors = 0, checked = 0;
  always #20 ref_clk = ~ref_clk;
  pcs_lane_test_monitor u_pcs_lane_test_monitor (.ref_clk(ref_clk),
    .reset(reset), .generic_phy_mode(gp), .lane0_elastic_fill(lanes[3:0]),
    .lane0_rx_event_code(lanes[6:4]), .lane0_invert_request(lanes[7]),
    .lane1_elastic_fill(lanes[11:8]), .lane1_rx_event_code(lanes[14:12]),
    .lane1_invert_request(lanes[15]), .lane2_elastic_fill(lanes[19:16]),
    .lane2_rx_event_code(lanes[22:20]), .lane2_invert_request(lanes[23]),
    .lane3_elastic_fill(lanes[27:24]), .lane3_rx_event_code(lanes[30:28]),
    .lane3_invert_request(lanes[31]), .obs_slice(obs), .reg_addr(addr),
    .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s),
    .reg_rdata(rdata), .irq(irq));
  debug_observer u_debug_observer (.ref_clk(ref_clk),
    .generic_phy_mode(gp), .obs_slice(obs), .lane_skew(skew),
    .top_dirty(dirty));
  // Lane N byte at bus 448+8N; top half zero; blank in generic mode
  function automatic logic [63:0] exp_obs(logic [31:0] v, logic g);
    return {32'h0, g ? 32'h0 : v};
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic drive(input logic [31:0] v, input logic g);
    @(posedge ref_clk);
    lanes <= v;
    gp <= g;
    @(posedge ref_clk);
    #1 check(obs, exp_obs(v, g));
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge ref_clk);
    wr_s <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(72));
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    // Every event code on all lanes, then random traffic
    for (int i = 0; i < 48; i++) begin
      l = $urandom;
      if (i < 8) l = (l & 32'h8F8F8F8F) | {4{1'b0, i[2:0], 4'h0}};
      drive(l, i >= 8 && i[2:0] == 3'h5);
    end
    $display("lane mapping test done");
    drive(32'h0, 1'b0);
    rd(4'h2, 32'h0);
    wr(4'h2, 32'hF);
    rd(4'h2, 32'hF);
    rd(4'h0, 32'hF);
    check(irq, 64'h1);
    // Status, fill and unmapped words ignore writes
    wr(4'h0, 32'h0);
    wr(4'h3, 32'hFFFF);
    wr(4'hA, 32'h0);
    rd(4'h0, 32'hF);
    rd(4'h2, 32'hF);
    wr(4'h1, 32'hF);
    rd(4'h0, 32'h0);
    check(irq, 64'h0);
    drive(32'h0050_0000, 1'b0);
    rd(4'h0, 32'h4);
    drive(32'h0, 1'b0);
    check(irq, 64'h1);
    wr(4'h2, 32'h3);
    check(irq, 64'h0);
    wr(4'h1, 32'h4);
    drive(32'h3030_3030, 1'b0);
    drive(32'h7070_7070, 1'b1);
    drive(32'h0, 1'b0);
    rd(4'h0, 32'h0);
    $display("status and interrupt test done");
    // Reset in mid-run clears fields, status and enable
    drive(32'h0040_0000, 1'b0);
    drive(32'hB3B3_B3B3, 1'b0);
    wr(4'h2, 32'hF);
    check(irq, 64'h1);
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1 check(obs, 64'h0);
    check(irq, 64'h0);
    rd(4'h2, 32'h0);
    rd(4'h0, 32'h0);
    $display("mid-run reset test done");
    drive(32'h0009_0305, 1'b0);
    rd(4'h3, 32'h0935);
    check(skew, 64'h2);
    rd(4'h9, 32'h0);
    rd(4'h1, 32'h0);
    check(dirty, 64'h0);
    $display("register map test done");
    conclude();
  end
endmodule
